// ==== logic/ccb_regs.svh ====
// Constants for the conditional branch and byte-operation execute block
// Notes on behaviour
// RQ1: Each operation reports issue, repeat and latency cycle counts.
// RQ2: Each flag is held, cleared, computed, or restored from a saved copy.
// RQ3: Codes 0000/1000 test overflow, 0001/1001 carry, 0010/1010 zero, set or clear.
// RQ4: 0011 carry or zero, 1011 neither; 0100 sign set, 1100 sign clear.
// RQ5: 0110/1110 sign xor overflow; 0111/1111 also or zero; 0101 always; 1101 saturation.
// RQ6: Taken branch adds sign-extended 9-bit displacement to pc, 2 cycles, flags held.
// RQ7: Untaken branch falls through in 1 cycle.
// RQ8: Conditional move picks first or second source by condition, 1 cycle, flags held.
// RQ9: Table call saves pc+2 and status, fetches table entry by 6-bit index, 4 cycles.
// RQ10: Word swap reverses byte order, 1 cycle, clears overflow, computes carry sign zero.
// RQ11: Halfword swap swaps bytes in each half, 1 cycle, same flag treatment.
// RQ12: Computed flags follow the result; unaffected flags keep their value.
// RQ13: Immediates and displacements sign-extend to 32 bits; the table-call index op_imm6 is zero-extended instead.
// RQ14: Add and compare update four flags; compare drops result; and clears overflow.
// RQ15: Call and debug returns restore pc and full status in 3 cycles.
`ifndef CCB_REGS_SVH
`define CCB_REGS_SVH
// ****************
// Status word bit positions
// ****************
`define CCB_PSW_Z    0
`define CCB_PSW_S    1
`define CCB_PSW_OV   2
`define CCB_PSW_CY   3
`define CCB_PSW_SAT  4
// ****************
// Cycle counts and program counter constants
// ****************
`define CCB_CYC_ONE      3'h1
`define CCB_CYC_BR_TAKEN 3'h2
`define CCB_CYC_RET      3'h3
`define CCB_CYC_CALL     3'h4
`define CCB_PC_STEP      32'h0000_0002
`define CCB_RESET_PC     32'h0000_0000
`endif

// ==== logic/ccb_pkg.sv ====
// Types for the conditional branch and byte-operation execute block
package ccb_pkg;
  typedef enum logic [3:0] {
    CCB_OP_NOP, CCB_OP_ADD, CCB_OP_CMP, CCB_OP_AND, CCB_OP_BCOND, CCB_OP_CONDITIONAL_MOVE,
    CCB_OP_BSW, CCB_OP_BSH, CCB_OP_TABLE_CALL, CCB_OP_TABLE_CALL_RETURN, CCB_OP_DEBUG_RETURN
  } ccb_op_t;
  typedef enum logic [1:0] {CCB_IDLE, CCB_BUSY, CCB_FETCH} ccb_state_t;
endpackage : ccb_pkg

// ==== logic/ccb_exec.sv ====
// Execute unit: condition codes, branch, move, swaps, table call and returns
`timescale 1ns/100ps
`include "ccb_regs.svh"
module ccb_exec
  import ccb_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        op_valid,
  input  wire ccb_op_t     op_code,
  input  wire logic [3:0]  op_cond,
  input  wire logic [31:0] op_src1,
  input  wire logic [31:0] op_src2,
  input  wire logic [4:0]  op_imm5,
  input  wire logic        op_use_imm,
  input  wire logic        op_subtract,
  input  wire logic [8:0]  op_disp9,
  input  wire logic [5:0]  op_imm6,
  input  wire logic [31:0] call_table_base,
  input  wire logic [31:0] debug_save_pc,
  input  wire logic [4:0]  debug_save_status,
  output logic             op_ready,
  output logic             table_rd_req,
  output logic [31:0]      table_rd_addr,
  input  wire logic        table_rd_valid,
  input  wire logic [31:0] table_rd_data,
  output logic             wb_valid,
  output logic [31:0]      wb_data,
  output logic [31:0]      pc,
  output logic [4:0]       program_status_word,
  output logic [31:0]      call_save_pc,
  output logic [4:0]       call_save_status,
  output logic [2:0]       issue_cycles,
  output logic [2:0]       repeat_cycles,
  output logic [2:0]       latency_cycles
);
  // ****************
  // State
  // ****************
  ccb_state_t  state_q, state_d;
  logic [2:0]  wait_q, wait_d;
  logic [31:0] pc_q, pc_d, csp_q, csp_d, wb_q, wb_d;
  logic [4:0]  psw_q, psw_d, css_q, css_d;
  logic        wbv_q, wbv_d;
  logic [2:0]  cyc_q, cyc_d;
  logic        cond_ok;
  logic [31:0] imm_ext, res;
  logic [32:0] sum;
  logic        fz, fs, fcy, fov;

  // RQ3 RQ4 RQ5 condition decode
  always_comb begin
    unique case (op_cond[2:0])
      3'h0: cond_ok = psw_q[`CCB_PSW_OV];
      3'h1: cond_ok = psw_q[`CCB_PSW_CY];
      3'h2: cond_ok = psw_q[`CCB_PSW_Z];
      3'h3: cond_ok = psw_q[`CCB_PSW_CY] | psw_q[`CCB_PSW_Z];
      3'h4: cond_ok = psw_q[`CCB_PSW_S];
      3'h5: cond_ok = 1'b1;
      3'h6: cond_ok = psw_q[`CCB_PSW_S] ^ psw_q[`CCB_PSW_OV];
      3'h7: cond_ok = (psw_q[`CCB_PSW_S] ^ psw_q[`CCB_PSW_OV]) | psw_q[`CCB_PSW_Z];
    endcase
    // Code 1101 is saturation, not the inverse of always
    if (op_cond == 4'hd) begin
      cond_ok = psw_q[`CCB_PSW_SAT];
    end else if (op_cond[3]) begin
      cond_ok = ~cond_ok;
    end
  end

  // RQ13 sign extension
  assign imm_ext = {{27{op_imm5[4]}}, op_imm5};

  // RQ14 arithmetic core
  always_comb begin
    logic [31:0] b;
    b   = op_use_imm ? imm_ext : op_src1;
    sum = op_subtract ? ({1'b0, op_src2} - {1'b0, b}) : ({1'b0, op_src2} + {1'b0, b});
    fcy = sum[32];
    fov = op_subtract ? ((op_src2[31] ^ b[31]) & (op_src2[31] ^ sum[31]))
                      : (~(op_src2[31] ^ b[31]) & (op_src2[31] ^ sum[31]));
    unique case (op_code)
      CCB_OP_AND: res = op_src2 & op_src1;
      // RQ10 word swap
      CCB_OP_BSW: res = {op_src2[7:0], op_src2[15:8], op_src2[23:16], op_src2[31:24]};
      // RQ11 halfword swap
      CCB_OP_BSH: res = {op_src2[23:16], op_src2[31:24], op_src2[7:0], op_src2[15:8]};
      default:    res = sum[31:0];
    endcase
    fz = (res == 32'h0000_0000);
    fs = res[31];
    // Swap carry: set when any result byte is zero for a word swap, or either byte of the low half for a halfword swap
    if (op_code == CCB_OP_BSW) begin
      fcy = (res[7:0] == 8'h00) | (res[15:8] == 8'h00) |
            (res[23:16] == 8'h00) | (res[31:24] == 8'h00);
    end else if (op_code == CCB_OP_BSH) begin
      fcy = (res[7:0] == 8'h00) | (res[15:8] == 8'h00);
    end
  end

  always_comb begin
    state_d = state_q;
    wait_d  = (wait_q != 3'h0) ? wait_q - 3'h1 : 3'h0;
    pc_d    = pc_q;
    psw_d   = psw_q;
    csp_d   = csp_q;
    css_d   = css_q;
    wb_d    = wb_q;
    wbv_d   = 1'b0;
    cyc_d   = cyc_q;
    unique case (state_q)
      CCB_IDLE: begin
        if (op_valid) begin
          // RQ1 default single-cycle timing
          cyc_d = `CCB_CYC_ONE;
          pc_d  = pc_q + `CCB_PC_STEP;
          unique case (op_code)
            CCB_OP_ADD, CCB_OP_CMP: begin
              // RQ2 RQ12 RQ14 four flags from result
              psw_d[`CCB_PSW_CY] = fcy;
              psw_d[`CCB_PSW_OV] = fov;
              psw_d[`CCB_PSW_S]  = fs;
              psw_d[`CCB_PSW_Z]  = fz;
              wbv_d = (op_code == CCB_OP_ADD);
              wb_d  = res;
            end
            CCB_OP_AND: begin
              // RQ14 clear overflow
              psw_d[`CCB_PSW_OV] = 1'b0;
              psw_d[`CCB_PSW_S]  = fs;
              psw_d[`CCB_PSW_Z]  = fz;
              wbv_d = 1'b1;
              wb_d  = res;
            end
            CCB_OP_BSW, CCB_OP_BSH: begin
              // RQ10 RQ11 swap flags
              psw_d[`CCB_PSW_CY] = fcy;
              psw_d[`CCB_PSW_OV] = 1'b0;
              psw_d[`CCB_PSW_S]  = fs;
              psw_d[`CCB_PSW_Z]  = fz;
              wbv_d = 1'b1;
              wb_d  = res;
            end
            CCB_OP_BCOND: begin
              if (cond_ok) begin
                // RQ6 RQ13 taken branch
                pc_d    = pc_q + {{23{op_disp9[8]}}, op_disp9};
                cyc_d   = `CCB_CYC_BR_TAKEN;
                state_d = CCB_BUSY;
                wait_d  = `CCB_CYC_BR_TAKEN - 3'h1;
              end
              // RQ7 fall through otherwise
            end
            CCB_OP_CONDITIONAL_MOVE: begin
              // RQ8 select by condition
              wbv_d = 1'b1;
              wb_d  = cond_ok ? (op_use_imm ? imm_ext : op_src1) : op_src2;
            end
            CCB_OP_TABLE_CALL: begin
              // RQ9 save and fetch
              csp_d   = pc_q + `CCB_PC_STEP;
              css_d   = psw_q;
              cyc_d   = `CCB_CYC_CALL;
              state_d = CCB_FETCH;
              wait_d  = `CCB_CYC_CALL - 3'h1;
            end
            CCB_OP_TABLE_CALL_RETURN, CCB_OP_DEBUG_RETURN: begin
              // RQ15 RQ2 restore
              pc_d    = (op_code == CCB_OP_TABLE_CALL_RETURN) ? csp_q : debug_save_pc;
              psw_d   = (op_code == CCB_OP_TABLE_CALL_RETURN) ? css_q : debug_save_status;
              cyc_d   = `CCB_CYC_RET;
              state_d = CCB_BUSY;
              wait_d  = `CCB_CYC_RET - 3'h1;
            end
            default: begin
            end
          endcase
        end
      end
      CCB_BUSY: begin
        if (wait_q == 3'h1) begin
          state_d = CCB_IDLE;
        end
      end
      CCB_FETCH: begin
        // Waits at least the documented count, longer if memory is slow
        wait_d = (wait_q > 3'h1) ? wait_q - 3'h1 : 3'h1;
        // The entry is a one-cycle pulse, so leave fetch on it and run out the count in busy
        if (table_rd_valid) begin
          pc_d    = call_table_base + table_rd_data;
          state_d = CCB_BUSY;
        end
      end
      default: state_d = CCB_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= CCB_IDLE;
      wait_q  <= 3'h0;
      pc_q    <= `CCB_RESET_PC;
      psw_q   <= 5'h00;
      csp_q   <= 32'h0000_0000;
      css_q   <= 5'h00;
      wb_q    <= 32'h0000_0000;
      wbv_q   <= 1'b0;
      cyc_q   <= `CCB_CYC_ONE;
    end else begin
      state_q <= state_d;
      wait_q  <= wait_d;
      pc_q    <= pc_d;
      psw_q   <= psw_d;
      csp_q   <= csp_d;
      css_q   <= css_d;
      wb_q    <= wb_d;
      wbv_q   <= wbv_d;
      cyc_q   <= cyc_d;
    end
  end

  // RQ9 table address, index scaled by two
  assign table_rd_req        = (state_q == CCB_FETCH);
  assign table_rd_addr       = call_table_base + {25'h0000000, op_imm6, 1'b0};
  assign op_ready            = (state_q == CCB_IDLE);
  assign wb_valid            = wbv_q;
  assign wb_data             = wb_q;
  assign pc                  = pc_q;
  assign program_status_word = psw_q;
  assign call_save_pc        = csp_q;
  assign call_save_status    = css_q;
  // RQ1 timing report
  assign issue_cycles        = cyc_q;
  assign repeat_cycles       = cyc_q;
  assign latency_cycles      = cyc_q;
endmodule : ccb_exec

// ==== test/ccb_exec_properties.sv ====
// Port assertions for the execute block
`timescale 1ns/100ps
module ccb_exec_chk
  import ccb_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        op_valid,
  input wire logic        op_ready,
  input wire ccb_op_t     op_code,
  input wire logic [8:0]  op_disp9,
  input wire logic        wb_valid,
  input wire logic [31:0] wb_data,
  input wire logic [31:0] pc,
  input wire logic [4:0]  program_status_word,
  input wire logic [2:0]  issue_cycles
);
  logic br, mv, sw, rt;
  assign br = op_valid && op_ready && op_code == CCB_OP_BCOND;
  assign mv = op_valid && op_ready && op_code == CCB_OP_CONDITIONAL_MOVE;
  assign sw = op_valid && op_ready && op_code inside {CCB_OP_BSW, CCB_OP_BSH};
  assign rt = op_valid && op_ready && op_code inside {CCB_OP_TABLE_CALL_RETURN, CCB_OP_DEBUG_RETURN};
  default clocking @(posedge mclk);
  endclocking
  default disable iff (reset);
  br_pc_a: assert property (br |=> pc == $past(pc) + (issue_cycles == 3'h2 ?
    {{23{$past(op_disp9[8])}}, $past(op_disp9)} : 32'h2)) else $error("bad pc");
  br_wait_a: assert property (br ##1 issue_cycles == 3'h2 |-> !op_ready ##1 op_ready)
    else $error("bad stall");
  hold_a: assert property (br || mv |=> $stable(program_status_word))
    else $error("flags moved");
  mv_wb_a: assert property (mv |=> wb_valid && op_ready) else $error("no result");
  sw_time_a: assert property (sw |=> wb_valid && issue_cycles == 3'h1)
    else $error("swap timing");
  sw_flag_a: assert property (sw |=> program_status_word[2:0] ==
    {1'h0, wb_data[31], wb_data == 32'h0}) else $error("swap flags");
  ret_a: assert property (rt |=> !op_ready [*2] ##1 op_ready) else $error("ret stall");
  ret_cyc_a: assert property (rt |=> issue_cycles == 3'h3) else $error("ret count");
endmodule : ccb_exec_chk
bind ccb_exec ccb_exec_chk u_chk (.*);

// ==== test/ccb_exec_bench.sv ====
// Self-checking bench for the execute block
`timescale 1ns/100ps
module ccb_exec_bench;
  import ccb_pkg::*;
  logic        mclk = 1'h0, reset = 1'h1, op_valid = 1'h0, table_rd_valid = 1'h0, t;
  logic        op_use_imm, op_subtract, op_ready, table_rd_req, wb_valid;
  ccb_op_t     op_code = CCB_OP_NOP;
  logic [3:0]  op_cond;
  logic [4:0]  op_imm5, debug_save_status, program_status_word, call_save_status, m_psw;
  logic [5:0]  op_imm6;
  logic [7:0]  v;
  logic [8:0]  op_disp9;
  logic [2:0]  issue_cycles, repeat_cycles, latency_cycles;
  logic [31:0] op_src1, op_src2, call_table_base, debug_save_pc, table_rd_data, table_rd_addr;
  logic [31:0] wb_data, pc, call_save_pc, m_pc, s_pc, e, rnd = 32'h44;
  int          miscompares = 0, num_checks = 0, i, n;
  ccb_exec u_ccb_exec (.*);
  initial forever #5 mclk = ~mclk;
  task nx;
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
  endtask : nx
  task chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
      miscompares++;
    end
  endtask : chk
  task wrap_up;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // Valid stays up after one-cycle ops, so they issue back to back
  task go(input ccb_op_t c, input logic hold);
    for (n = 0; n < 20 && op_ready !== 1'h1; n++) @(negedge mclk);
    miscompares += (op_ready !== 1'h1);
    if (op_ready !== 1'h1) wrap_up();
    op_code = c;
    if (!op_valid) op_valid = 1'h1;
    @(negedge mclk);
    op_valid = hold;
  endtask : go
  task cmp(input logic [2:0] cy);
    chk(pc, m_pc);
    chk(32'({program_status_word, issue_cycles, repeat_cycles, latency_cycles}), 32'({m_psw, {3{cy}}}));
  endtask : cmp
  initial begin
    {op_use_imm, op_subtract, op_cond, op_imm5, op_imm6, op_disp9, op_src1, op_src2} = '0;
    {call_table_base, debug_save_pc, debug_save_status, table_rd_data} = '0;
    repeat (16) @(negedge mclk);
    reset = 1'h0;
    {m_pc, m_psw} = '0;
    cmp(3'h1);
    for (i = 0; i < 48; i++) begin
      nx();
      {debug_save_pc, debug_save_status} = {rnd, rnd[8:4]};
      {op_cond, op_disp9, op_src1, op_src2, op_imm5, op_use_imm} = {i[3:0], rnd[20:12], ~rnd, rnd, rnd[4:0], rnd[9]};
      go(CCB_OP_DEBUG_RETURN, 1'h0);
      {m_pc, m_psw} = {debug_save_pc, debug_save_status};
      cmp(3'h3);
      v = {(m_psw[1] ^ m_psw[2]) | m_psw[0], m_psw[1] ^ m_psw[2], 1'h1, m_psw[1],
           m_psw[3] | m_psw[0], m_psw[0], m_psw[3], m_psw[2]};
      t = (op_cond == 4'hd) ? m_psw[4] : op_cond[3] ^ v[op_cond[2:0]];
      go(CCB_OP_BCOND, !t);
      m_pc += t ? {{23{op_disp9[8]}}, op_disp9} : 32'h2;
      cmp(t ? 3'h2 : 3'h1);
      go(CCB_OP_CONDITIONAL_MOVE, 1'h1);
      m_pc += 32'h2;
      cmp(3'h1);
      chk(wb_data, !t ? op_src2 : op_use_imm ? {{27{op_imm5[4]}}, op_imm5} : op_src1);
    end
    $display("test branch and move done");
    for (i = 0; i < 6; i++) begin
      nx();
      op_src2 = (i > 3) ? rnd & 32'hff00_ff00 : rnd;
      e = {<<8{op_src2}};
      if (i[0]) e = {e[15:0], e[31:16]};
      t = e[7:0] == 8'h0 || e[15:8] == 8'h0 || (!i[0] && (e[23:16] == 8'h0 || e[31:24] == 8'h0));
      go(i[0] ? CCB_OP_BSH : CCB_OP_BSW, 1'h1);
      m_pc += 32'h2;
      m_psw = {m_psw[4], t, 1'h0, e[31], e == 32'h0};
      cmp(3'h1);
      chk(wb_data, e);
    end
    $display("test byte swaps done");
    for (i = 0; i < 6; i++) begin
      nx();
      {op_src1, op_src2, op_subtract, op_use_imm} = {rnd, ~rnd ^ (rnd << 3), rnd[i], 1'h0};
      {t, e} = op_subtract ? {1'h0, op_src2} - {1'h0, op_src1} : {1'h0, op_src2} + {1'h0, op_src1};
      v[0] = (op_subtract ^ (op_src2[31] == op_src1[31])) && (e[31] != op_src2[31]);
      go(i[1] ? CCB_OP_CMP : CCB_OP_ADD, 1'h1);
      m_pc += 32'h2;
      m_psw = {m_psw[4], t, v[0], e[31], e == 32'h0};
      cmp(3'h1);
      if (!i[1]) chk(wb_data, e);
      go(CCB_OP_AND, 1'h1);
      e = op_src2 & op_src1;
      m_pc += 32'h2;
      m_psw = {m_psw[4:3], 1'h0, e[31], e == 32'h0};
      cmp(3'h1);
      chk(wb_data, e);
    end
    $display("test arithmetic done");
    nx();
    {call_table_base, table_rd_data, op_imm6} = {rnd, rnd ^ 32'h5a5a_5a5a, rnd[13:8]};
    s_pc = m_pc + 32'h2;
    go(CCB_OP_TABLE_CALL, 1'h0);
    for (n = 0; n < 20 && table_rd_req !== 1'h1; n++) @(negedge mclk);
    chk(table_rd_addr, call_table_base + {25'h0, op_imm6, 1'h0});
    table_rd_valid = 1'h1;
    @(negedge mclk);
    table_rd_valid = 1'h0;
    for (n = 0; n < 20 && op_ready !== 1'h1; n++) @(negedge mclk);
    m_pc = call_table_base + table_rd_data;
    cmp(3'h4);
    chk(call_save_pc, s_pc);
    chk(32'(call_save_status), 32'(m_psw));
    go(CCB_OP_TABLE_CALL_RETURN, 1'h0);
    m_pc = s_pc;
    cmp(3'h3);
    $display("test table call done");
    wrap_up();
  end
endmodule : ccb_exec_bench
